// ===== rtl/flash_selfprog_ctrl.sv
// Flash self-programming controller: command sequencer, page buffer,
// lock/fuse read-back and read-while-write busy handling.
// Assumes a flash array that answers cmd with a one-cycle done pulse.
`timescale 1ns/1ps
`default_nettype none

module flash_selfprog_ctrl
    import flash_selfprog_pkg::*;
(
    // System
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              cyc_i,
    input  wire logic              stb_i,
    input  wire logic              we_i,
    input  wire logic [7:0]        adr_i,
    input  wire logic [3:0]        sel_i,
    input  wire logic [31:0]       dat_i,
    output logic      [31:0]       dat_o,
    output logic                   ack_o,
    // Fuses and external chip erase
    input  wire fuse_bytes_t       fuses_i,
    input  wire logic              chip_erase_i,
    input  wire logic              eeprom_write_pending_i,
    // Flash array
    output flash_cmd_t             flash_cmd_o,
    output logic [PAGE_BITS-1:0]   buf_addr_o,
    output logic [15:0]            buf_data_o,
    input  wire logic [15:0]       flash_rdata_i,
    output logic [15:0]            flash_raddr_o,
    input  wire logic              flash_done_i,
    // Core
    output logic [15:0]            reset_vector_o,
    output logic                   core_halt_o,
    output logic                   irq_o
);

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ARMED = 4'b0010,
        ST_BUSY  = 4'b0100,
        ST_READ  = 4'b1000
    } state_t;

    // Software-visible state
    state_t                state_reg;
    logic [7:0]            ctrl_reg;
    logic [15:0]           pointer_reg;
    logic [15:0]           data_reg;
    logic [2:0]            window_reg;
    logic                  busy_reg;
    logic [7:0]            lock_reg;

    // Temporary page buffer and its scan counter
    logic [15:0]           page_buf [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] buf_valid_reg;
    logic [PAGE_BITS-1:0]  scan_reg;

    // Bus decode and read-back
    logic                  bus_hit;
    logic                  wr_ctrl;
    logic                  wr_store;
    logic                  rd_load;
    logic [5:0]            cmd_pat;
    logic [7:0]            load_byte;
    logic [7:0]            read_byte;

    // Byte of a word chosen by the pointer's lowest bit
    function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic sel);
        pick_byte = sel ? w[15:8] : w[7:0];
    endfunction

    // Page lies in the no-readwhile section
    function automatic logic is_no_readwhile_section(input logic [PAGE_BITS-1:0] page);
        is_no_readwhile_section = page >= NO_READWHILE_SECTION_FIRST_PAGE;
    endfunction

    // Store strobe taken while armed with one pattern
    function automatic logic armed_store(input state_t st, input logic hit,
                                         input logic [5:0] pat, input logic [5:0] want);
        armed_store = st == ST_ARMED && hit && pat == want;
    endfunction

    assign bus_hit  = cyc_i && stb_i && !ack_o;
    // Control writes refused while an eeprom write pends
    assign wr_ctrl  = bus_hit && we_i && sel_i[0] && adr_i == CTRL_OFFSET
                      && !eeprom_write_pending_i;
    // Any write to the store offset is a store op
    assign wr_store = bus_hit && we_i && adr_i == STORE_OFFSET;
    assign rd_load  = bus_hit && !we_i && adr_i == LOAD_OFFSET;
    assign cmd_pat  = ctrl_reg[5:0];

    // Load: pointer bit 0 picks byte of addressed word
    assign load_byte = pick_byte(flash_rdata_i, pointer_reg[0]);

    // Fuse/lock read-back, raw programmed=0 values
    always_comb begin
        // Unmapped pointers read as unprogrammed
        case (pointer_reg)
            PTR_FUSE_LOW:  read_byte = fuses_i.low;
            PTR_LOCK:      read_byte = lock_reg;
            PTR_FUSE_EXT:  read_byte = fuses_i.ext;
            PTR_FUSE_HIGH: read_byte = fuses_i.high;
            default:       read_byte = 8'hFF;
        endcase
    end

    // Reset vector, fuses are inputs only
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_vector_o <= APP_RESET_ADDR;
        end else begin
            // Bit 0 of the high fuse byte picks the vector
            reset_vector_o <= fuses_i.high[0] ? APP_RESET_ADDR : BOOT_RESET_ADDR;
        end
    end

    // Pointer and data registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pointer_reg <= 16'h0000;
            data_reg    <= 16'h0000;
        end else if (bus_hit && we_i) begin
            if (adr_i == POINTER_OFFSET) begin
                pointer_reg <= dat_i[15:0];
            end
            // Data pair feeds buffer loads and lock setting
            if (adr_i == DATA_OFFSET) begin
                data_reg <= dat_i[15:0];
            end
        end
    end

    // Wishbone answer, one wait state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_hit;
            dat_o <= 32'h0000_0000;
            // Read data registered together with ack
            if (bus_hit && !we_i) begin
                case (adr_i)
                    CTRL_OFFSET:    dat_o <= {24'h0, ctrl_reg[7], busy_reg, ctrl_reg[5:0]};
                    POINTER_OFFSET: dat_o <= {16'h0, pointer_reg};
                    DATA_OFFSET:    dat_o <= {16'h0, data_reg};
                    LOAD_OFFSET:    dat_o <= {24'h0,
                                        (state_reg == ST_READ) ? read_byte : load_byte};
                    STATUS_OFFSET:  dat_o <= {24'h0, lock_reg};
                    default:        dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Command sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg   <= ST_IDLE;
            ctrl_reg    <= CTRL_RESET;
            window_reg  <= 3'd0;
            flash_cmd_o <= '0;
        end else begin
            flash_cmd_o.req <= 1'b0;
            // Control bits frozen while the array is busy
            if (wr_ctrl && state_reg != ST_BUSY) begin
                ctrl_reg[7]   <= dat_i[INT_EN_BIT];
                ctrl_reg[5:0] <= dat_i[5:0];
            end
            case (state_reg)
                ST_IDLE: begin
                    // Lock pattern opens a read window, others arm
                    if (wr_ctrl && dat_i[ENABLE_BIT]) begin
                        window_reg <= (dat_i[5:0] == CMD_LOCK) ? LOAD_WINDOW : STORE_WINDOW;
                        state_reg  <= (dat_i[5:0] == CMD_LOCK) ? ST_READ : ST_ARMED;
                    end
                end
                ST_ARMED, ST_READ: begin
                    // Store inside the window launches or drops
                    if (wr_store && !eeprom_write_pending_i) begin
                        window_reg <= 3'd0;
                        if (cmd_pat == CMD_ERASE || cmd_pat == CMD_WRITE || cmd_pat == CMD_LOCK) begin
                            // Latch target so pointer may change
                            flash_cmd_o.req       <= 1'b1;
                            flash_cmd_o.erase     <= cmd_pat == CMD_ERASE;
                            flash_cmd_o.write     <= cmd_pat == CMD_WRITE;
                            flash_cmd_o.lock      <= cmd_pat == CMD_LOCK;
                            flash_cmd_o.page      <= pointer_reg[15:16-PAGE_BITS];
                            flash_cmd_o.lock_bits <= data_reg[5:0];
                            state_reg             <= ST_BUSY;
                        end else begin
                            ctrl_reg[5:0] <= 6'h00;
                            state_reg     <= ST_IDLE;
                        end
                    end else if (state_reg == ST_READ && rd_load) begin
                        ctrl_reg[5:0] <= 6'h00;
                        state_reg     <= ST_IDLE;
                    end else if (window_reg == 3'd1) begin
                        ctrl_reg[5:0] <= 6'h00;
                        state_reg     <= ST_IDLE;
                    end else begin
                        // Count down; lock read narrows to load window
                        window_reg <= window_reg - 3'd1;
                        if (state_reg == ST_READ && window_reg == STORE_WINDOW - LOAD_WINDOW + 3'd1) begin
                            state_reg <= ST_ARMED;
                        end
                    end
                end
                ST_BUSY: begin
                    // Wait for the array to finish
                    if (flash_done_i) begin
                        ctrl_reg[5:0] <= 6'h00;
                        state_reg     <= ST_IDLE;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
            // Lock read window is 3 for loads but 4 for stores
            if (state_reg == ST_IDLE && wr_ctrl && dat_i[5:0] == CMD_LOCK) begin
                window_reg <= STORE_WINDOW;
            end
        end
    end

    // Halt core while programming the no-readwhile section
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            core_halt_o <= 1'b0;
        end else if (flash_cmd_o.req && !flash_cmd_o.lock) begin
            core_halt_o <= is_no_readwhile_section(flash_cmd_o.page);
        end else if (flash_done_i) begin
            // Released when the array reports done
            core_halt_o <= 1'b0;
        end
    end

    // Readwhile section busy flag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_reg <= 1'b0;
        end else if (flash_cmd_o.req && !flash_cmd_o.lock && !is_no_readwhile_section(flash_cmd_o.page)) begin
            busy_reg <= 1'b1;
        end else if (armed_store(state_reg, wr_store, cmd_pat, CMD_REENABLE)
                     && !core_halt_o && !flash_cmd_o.req) begin
            busy_reg <= 1'b0;
        end
    end

    // Lock bits: set by software, cleared only by chip erase or reset
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lock_reg <= LOCK_RESET;
        end else if (chip_erase_i) begin
            lock_reg <= LOCK_RESET;
        end else if (flash_cmd_o.req && flash_cmd_o.lock) begin
            // Only bits 5..0 settable; programmed bits stay programmed
            lock_reg[5:0] <= lock_reg[5:0] & flash_cmd_o.lock_bits;
        end
    end

    // Temporary page buffer valid bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_valid_reg <= '0;
        end else if (eeprom_write_pending_i && |buf_valid_reg) begin
            // Eeprom write loses a partly loaded page
            buf_valid_reg <= '0;
        end else if ((state_reg == ST_BUSY && flash_done_i && flash_cmd_o.write)
                     || armed_store(state_reg, wr_store, cmd_pat, CMD_REENABLE)) begin
            buf_valid_reg <= '0;
        end else if (armed_store(state_reg, wr_store, cmd_pat, CMD_LOAD_BUF)
                     && !eeprom_write_pending_i) begin
            buf_valid_reg[pointer_reg[WORD_BITS-1:0]] <= 1'b1;
        end
    end

    // Buffer storage
    always_ff @(posedge clk_i) begin
        if (armed_store(state_reg, wr_store, cmd_pat, CMD_LOAD_BUF)) begin
            page_buf[pointer_reg[WORD_BITS-1:0]] <= data_reg;
        end
    end

    // Buffer read port to flash array, erased value when unloaded
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_reg   <= '0;
            buf_addr_o <= '0;
            buf_data_o <= ERASED_WORD;
        end else begin
            // Address and data launched together so they pair
            scan_reg   <= scan_reg + 9'd1;
            buf_addr_o <= scan_reg;
            buf_data_o <= buf_valid_reg[scan_reg[WORD_BITS-1:0]]
                          ? page_buf[scan_reg[WORD_BITS-1:0]] : ERASED_WORD;
        end
    end

    // Flash read address, blocked for readwhile-section addresses while busy
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flash_raddr_o <= 16'h0000;
        end else if (!(busy_reg && pointer_reg[15:1] < {NO_READWHILE_SECTION_FIRST_PAGE, 6'h00})) begin
            flash_raddr_o <= {1'b0, pointer_reg[15:1]};
        end
    end

    // Level interrupt while enable is clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            // Stays high until software rewrites control
            irq_o <= ctrl_reg[7] && (state_reg == ST_IDLE);
        end
    end

endmodule

`default_nettype wire

// ===== common/flash_selfprog_pkg.sv
// Constants and carrier types for the flash self-programming controller.
// Assumes a 25 MHz system clock and a 16-bit word-addressed flash array.
package flash_selfprog_pkg;

    // Register map, word aligned on classic Wishbone
    localparam logic [7:0] CTRL_OFFSET    = 8'h00;
    localparam logic [7:0] POINTER_OFFSET = 8'h04;
    localparam logic [7:0] DATA_OFFSET    = 8'h08;
    localparam logic [7:0] LOAD_OFFSET    = 8'h0C;
    localparam logic [7:0] STORE_OFFSET   = 8'h10;
    localparam logic [7:0] STATUS_OFFSET  = 8'h14;

    // Control register fields
    localparam int ENABLE_BIT   = 0;
    localparam int ERASE_BIT    = 1;
    localparam int WRITE_BIT    = 2;
    localparam int LOCK_BIT     = 3;
    localparam int REENABLE_BIT = 4;
    localparam int BUSY_BIT     = 6;
    localparam int INT_EN_BIT   = 7;

    // Command patterns on bits 5..0
    localparam logic [5:0] CMD_LOAD_BUF = 6'h01;
    localparam logic [5:0] CMD_ERASE    = 6'h03;
    localparam logic [5:0] CMD_WRITE    = 6'h05;
    localparam logic [5:0] CMD_LOCK     = 6'h09;
    localparam logic [5:0] CMD_REENABLE = 6'h11;

    // Geometry: 128 words per page, 512 pages
    localparam int WORD_BITS = 7;
    localparam int PAGE_BITS = 9;
    localparam int PAGE_WORDS = 128;

    localparam logic [15:0] APP_RESET_ADDR  = 16'h0000;
    localparam logic [15:0] BOOT_RESET_ADDR = 16'h7000;
    localparam logic [PAGE_BITS-1:0] NO_READWHILE_SECTION_FIRST_PAGE = 9'h1C0;

    // Read-back pointer values
    localparam logic [15:0] PTR_FUSE_LOW  = 16'h0000;
    localparam logic [15:0] PTR_LOCK      = 16'h0001;
    localparam logic [15:0] PTR_FUSE_EXT  = 16'h0002;
    localparam logic [15:0] PTR_FUSE_HIGH = 16'h0003;

    // Timing windows in clock cycles
    localparam logic [2:0] STORE_WINDOW = 3'd4;
    localparam logic [2:0] LOAD_WINDOW  = 3'd3;

    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [7:0]  LOCK_RESET   = 8'hFF;
    localparam logic [15:0] ERASED_WORD  = 16'hFFFF;

    typedef struct packed {
        logic                 req;
        logic                 erase;
        logic                 write;
        logic                 lock;
        logic [PAGE_BITS-1:0] page;
        logic [5:0]           lock_bits;
    } flash_cmd_t;

    typedef struct packed {
        logic [7:0] low;
        logic [7:0] high;
        logic [7:0] ext;
    } fuse_bytes_t;

endpackage

// ===== verif/flash_selfprog_ctrl_properties.sv
// Port checker for the flash self-programming controller.
// Assumes it is bound onto flash_selfprog_ctrl, one clock domain.
`timescale 1ns/1ps
`default_nettype none
module flash_selfprog_ctrl_properties
    import flash_selfprog_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        ack_o,
    input wire logic        eeprom_write_pending_i,
    input wire fuse_bytes_t fuses_i,
    input wire flash_cmd_t  flash_cmd_o,
    input wire logic [15:0] reset_vector_o,
    input wire logic        core_halt_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
    property p_ack_answer; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not answered");
    property p_reset_vector;
        !$past(rst_i) |-> reset_vector_o == ($past(fuses_i.high[0]) ? APP_RESET_ADDR : BOOT_RESET_ADDR);
    endproperty
    a_reset_vector: assert property (p_reset_vector) else $error("wrong reset vector");
    property p_req_pulse; flash_cmd_o.req |=> !flash_cmd_o.req; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("flash request too long");
    property p_halt_cause;
        $rose(core_halt_o) |-> $past(flash_cmd_o.req) && !$past(flash_cmd_o.lock);
    endproperty
    a_halt_cause: assert property (p_halt_cause) else $error("halt without request");
    property p_no_readwhile_section_halts;
        flash_cmd_o.req && !flash_cmd_o.lock && flash_cmd_o.page >= NO_READWHILE_SECTION_FIRST_PAGE |=> core_halt_o;
    endproperty
    a_no_readwhile_section_halts: assert property (p_no_readwhile_section_halts) else $error("core not halted");
    property p_lock_no_halt; flash_cmd_o.req && flash_cmd_o.lock |=> !core_halt_o [*2]; endproperty
    a_lock_no_halt: assert property (p_lock_no_halt) else $error("halt on lock set");
    property p_eeprom_refuse; eeprom_write_pending_i [*8] |-> !flash_cmd_o.req; endproperty
    a_eeprom_refuse: assert property (p_eeprom_refuse) else $error("request while eeprom busy");
    c_erase: cover property (flash_cmd_o.req && flash_cmd_o.erase);
    c_write: cover property (flash_cmd_o.req && flash_cmd_o.write);
    c_halt: cover property ($rose(core_halt_o));
endmodule
bind flash_selfprog_ctrl flash_selfprog_ctrl_properties chk (.*);
`default_nettype wire

// ===== verif/flash_array_model.sv
// Flash array model: answers each request with a done pulse.
// Assumes the controller pulses req for one cycle.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
    import flash_selfprog_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire flash_cmd_t  cmd_i,
    input  wire logic [15:0] raddr_i,
    input  wire logic [3:0]  delay_i,
    output logic [15:0]      rdata_o,
    output logic             done_o,
    output flash_cmd_t       last_o,
    output int               count_o
);
    logic [4:0] cnt_reg;
    // Data tied to address so a stale word shows
    assign rdata_o = ~raddr_i;
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            cnt_reg <= 5'h00;
            count_o <= 0;
        end else if (cmd_i.req) begin
            cnt_reg <= {1'b0, delay_i} + 5'h01;
            last_o  <= cmd_i;
            count_o <= count_o + 1;
        end else if (cnt_reg != 5'h00) begin
            cnt_reg <= cnt_reg - 5'h01;
            done_o  <= (cnt_reg == 5'h01);
        end
    end
endmodule
`default_nettype wire

// ===== verif/flash_self_programming_control_test.sv
// Self-checking bench for flash_selfprog_ctrl with a flash array model.
// Assumes a 25 MHz clock and the package register map.
`timescale 1ns/1ps
`default_nettype none
module flash_self_programming_control_test import flash_selfprog_pkg::*;;
    logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, chip_erase_i, ee_i, done, halt, irq;
    logic [7:0] adr_i, d, lock_exp;
    logic [3:0] sel_i, delay;
    logic [31:0] dat_i, dat_o, q;
    logic [15:0] rdata, raddr, rvec, buf_data, p, w;
    logic [8:0] buf_addr;
    fuse_bytes_t fuses_i;
    flash_cmd_t cmd, last;
    int err_count, checks, seed, req_count, n;
    flash_selfprog_ctrl uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .fuses_i(fuses_i), .chip_erase_i(chip_erase_i), .eeprom_write_pending_i(ee_i),
        .flash_cmd_o(cmd), .buf_addr_o(buf_addr), .buf_data_o(buf_data), .flash_rdata_i(rdata),
        .flash_raddr_o(raddr), .flash_done_i(done), .reset_vector_o(rvec), .core_halt_o(halt),
        .irq_o(irq));
    flash_array_model far (.clk_i(clk_i), .rst_i(rst_i), .cmd_i(cmd), .raddr_i(raddr),
        .delay_i(delay), .rdata_o(rdata), .done_o(done), .last_o(last), .count_o(req_count));
    task automatic conclude;
        if (err_count == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic timeout;
        err_count++;
        $display("ERROR %0t wait ran out", $time);
        conclude();
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] v, output logic [31:0] r);
        int k;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= wr;
        sel_i <= 4'hF;
        adr_i <= a;
        dat_i <= v;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack_o !== 1'b1 && k < 20);
        if (ack_o !== 1'b1) timeout();
        r = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic op(input logic [7:0] c, input logic [15:0] ptr);
        bus(1'b1, POINTER_OFFSET, {16'h0000, ptr}, q);
        bus(1'b1, CTRL_OFFSET, {24'h000000, c}, q);
        bus(1'b1, STORE_OFFSET, 32'h00000000, q);
    endtask
    task automatic wait_irq;
        int k;
        for (k = 0; k < 200 && irq !== 1'b1; k++) @(posedge clk_i);
        if (irq !== 1'b1) timeout();
    endtask
    task automatic scan(input logic [6:0] wi, input logic [15:0] e);
        int k;
        for (k = 0; k < 300 && buf_addr[6:0] !== wi; k++) @(posedge clk_i);
        if (buf_addr[6:0] !== wi) timeout();
        chk(buf_data, e);
    endtask
    function automatic logic [7:0] exp_rb(input int i);
        case (i)
            0: return fuses_i.low;
            1: return lock_exp;
            2: return fuses_i.ext;
            default: return fuses_i.high;
        endcase
    endfunction
    task automatic rb;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, POINTER_OFFSET, i, q);
            bus(1'b1, CTRL_OFFSET, 32'h00000009, q);
            bus(1'b0, LOAD_OFFSET, 32'h00000000, q);
            chk({8'h00, q[7:0]}, {8'h00, exp_rb(i)});
        end
    endtask
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        timeout();
    end
    initial begin
        seed = 86;
        err_count = 0;
        checks = 0;
        lock_exp = 8'hFF;
        {cyc_i, stb_i, we_i, chip_erase_i, ee_i} = 5'h00;
        adr_i = 8'h00;
        dat_i = 32'h00000000;
        sel_i = 4'hF;
        delay = 4'hC;
        rst_i = 1'b1;
        fuses_i = 24'($random(seed));
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(rvec, fuses_i.high[0] ? APP_RESET_ADDR : BOOT_RESET_ADDR);
        rb();
        bus(1'b0, CTRL_OFFSET, 32'h00000000, q);
        chk({10'h000, q[5:0]}, 16'h0000);
        p = 16'($random(seed));
        bus(1'b1, POINTER_OFFSET, {16'h0000, p}, q);
        bus(1'b0, LOAD_OFFSET, 32'h00000000, q);
        w = ~{1'b0, p[15:1]};
        chk({8'h00, q[7:0]}, {8'h00, p[0] ? w[15:8] : w[7:0]});
        d = (8'($random(seed)) | 8'hC0) & 8'hFE;
        lock_exp = lock_exp & d;
        bus(1'b1, DATA_OFFSET, {24'h000000, d}, q);
        delay = 4'h1;
        op(8'h89, PTR_LOCK);
        wait_irq();
        bus(1'b0, STATUS_OFFSET, 32'h00000000, q);
        chk({8'h00, q[7:0]}, {8'h00, lock_exp});
        rb();
        chip_erase_i <= 1'b1;
        @(posedge clk_i);
        chip_erase_i <= 1'b0;
        lock_exp = 8'hFF;
        @(posedge clk_i);
        rb();
        delay = 4'hC;
        for (int k = 0; k < 2; k++) begin
            p = 16'($random(seed));
            if (k == 1) p = {3'b111, p[12:7], 7'h00};
            else p[15] = 1'b0;
            op(k == 1 ? 8'h85 : 8'h83, p);
            bus(1'b1, POINTER_OFFSET, {16'h0000, ~p}, q);
            chk({14'h0000, halt, irq}, {14'h0000, k[0], 1'b0});
            wait_irq();
            chk({7'h00, last.page}, {7'h00, p[15:7]});
            chk({14'h0000, last.erase, last.write}, k == 1 ? 16'h0001 : 16'h0002);
            bus(1'b0, CTRL_OFFSET, 32'h00000000, q);
            if (k == 0) chk({15'h0000, q[BUSY_BIT]}, 16'h0001);
            op(8'h11, p);
            bus(1'b0, CTRL_OFFSET, 32'h00000000, q);
            chk({15'h0000, q[BUSY_BIT]}, 16'h0000);
        end
        n = req_count;
        bus(1'b1, CTRL_OFFSET, 32'h00000003, q);
        repeat (8) @(posedge clk_i);
        bus(1'b1, STORE_OFFSET, 32'h00000000, q);
        bus(1'b0, CTRL_OFFSET, 32'h00000000, q);
        chk({10'h000, q[5:0]}, 16'h0000);
        ee_i <= 1'b1;
        op(8'h03, p);
        ee_i <= 1'b0;
        chk(16'(req_count - n), 16'h0000);
        p = {9'h000, 7'($random(seed))};
        w = 16'($random(seed));
        bus(1'b1, DATA_OFFSET, {16'h0000, w}, q);
        op(8'h01, p);
        scan(p[6:0], w);
        op(8'h11, p);
        scan(p[6:0], ERASED_WORD);
        op(8'h01, p);
        ee_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        ee_i <= 1'b0;
        scan(p[6:0], ERASED_WORD);
        conclude();
    end
endmodule
`default_nettype wire
